// >>> design/hwm_defines.svh
// Notes on behaviour
// - A multiply finishes in one instruction cycle with no stall.
// - Both operands are unsigned and the full 16-bit product is kept.
// - The product's upper byte goes to the high product byte, lower to low.
// - A multiply never changes any flag of the ALU status register.
// - One operand always comes from the working register.
`ifndef HWM_DEFINES_SVH
`define HWM_DEFINES_SVH
`define HWM_OP_W       8
`define HWM_PROD_W     16
`define HWM_PROD_RESET 16'h0000
`define HWM_STAT_W     8
`define HWM_STAT_RESET 8'h00
`define HWM_DONE_RESET 1'b0
`endif

// >>> design/hwm_multiplier.sv
`timescale 1ns/10ps
`include "hwm_defines.svh"
module hwm_multiplier (
	// Clock and reset
	input  wire logic                  i_clk,
	input  wire logic                  i_rst_n,
	input  wire logic                  i_ce,
	// Multiply request from instruction execution
	input  wire logic                  i_mul_en,
	input  wire logic [7:0]            i_working_register,
	input  wire logic [7:0]            i_operand,
	// Direct software writes to the product bytes
	input  wire hwm_pkg::hwm_prodwr_type i_prod_wr,
	// ALU status from the core, passed through untouched
	input  wire logic [7:0]            i_alu_status_register,
	// Results
	output logic [7:0]                 o_product_high_byte,
	output logic [7:0]                 o_product_low_byte,
	output logic [7:0]                 o_alu_status_register,
	output logic                       o_mul_done
);
	hwm_pkg::hwm_prod_type prod_reg;
	hwm_pkg::hwm_prod_type prod_next;
	logic [7:0]            stat_reg;
	logic [7:0]            stat_next;
	logic                  done_reg;
	logic                  done_next;
	logic [15:0]           mul_full;

	// Full width product, no truncation
	assign mul_full = 16'(i_working_register) * 16'(i_operand);

	// Product group: multiply wins over a same-cycle byte write,
	// as the multiply is the later op of the instruction
	always_comb begin
		prod_next = prod_reg;
		if (i_mul_en) begin
			prod_next.high_byte = mul_full[15:8];
			prod_next.low_byte  = mul_full[7:0];
		end else begin
			if (i_prod_wr.wr_high)
				prod_next.high_byte = i_prod_wr.data;
			if (i_prod_wr.wr_low)
				prod_next.low_byte = i_prod_wr.data;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			prod_reg <= `HWM_PROD_RESET;
		end else if (i_ce) begin
			prod_reg <= prod_next;
		end
	end

	// Status group: a plain copy, so no multiply path reaches a flag
	always_comb begin
		stat_next = i_alu_status_register;
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			stat_reg <= `HWM_STAT_RESET;
		end else if (i_ce) begin
			stat_reg <= stat_next;
		end
	end

	// Done group: one pulse per accepted multiply, no stall state
	always_comb begin
		done_next = i_mul_en;
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			done_reg <= `HWM_DONE_RESET;
		end else if (i_ce) begin
			done_reg <= done_next;
		end
	end

	assign o_product_high_byte  = prod_reg.high_byte;
	assign o_product_low_byte   = prod_reg.low_byte;
	assign o_alu_status_register = stat_reg;
	assign o_mul_done           = done_reg;

	property p_product;
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && i_mul_en) |=> {o_product_high_byte, o_product_low_byte}
			== $past(i_working_register) * $past(i_operand);
	endproperty
	a_product: assert property (p_product)
		else $error("product wrong after multiply");

	property p_high;
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && i_mul_en) |=> o_product_high_byte
			== 8'(({8'h00, $past(i_working_register)}
			* {8'h00, $past(i_operand)}) >> 8);
	endproperty
	a_high: assert property (p_high)
		else $error("high byte wrong");

	property p_flags;
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && i_mul_en) |=> o_alu_status_register
			== $past(i_alu_status_register);
	endproperty
	a_flags: assert property (p_flags)
		else $error("status flags altered by multiply");

	property p_single;
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && i_mul_en) |=> o_mul_done;
	endproperty
	a_single: assert property (p_single)
		else $error("multiply took more than one cycle");

	property p_hold;
		@(posedge i_clk) disable iff (!i_rst_n)
		(!i_ce) |=> $stable(o_product_low_byte) && $stable(o_mul_done);
	endproperty
	a_hold: assert property (p_hold)
		else $error("state moved with enable low");

	property p_working_register;
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && i_mul_en && i_working_register == 8'h00)
			|=> o_product_low_byte == 8'h00 && o_product_high_byte == 8'h00;
	endproperty
	a_working_register: assert property (p_working_register)
		else $error("zero working register gave nonzero product");

	property p_working_register_one;
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && i_mul_en && i_working_register == 8'h01)
			|=> {o_product_high_byte, o_product_low_byte}
			== {8'h00, $past(i_operand)};
	endproperty
	a_working_register_one: assert property (p_working_register_one)
		else $error("unit working register did not pass operand");

	property p_low;
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && i_mul_en) |=> o_product_low_byte
			== 8'($past(i_working_register) * $past(i_operand));
	endproperty
	a_low: assert property (p_low)
		else $error("low byte wrong");

	property p_done_low;
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && !i_mul_en)
			|=> !o_mul_done;
	endproperty
	a_done_low: assert property (p_done_low)
		else $error("done stayed high without a multiply");

	property p_done_only_mul;
		@(posedge i_clk) disable iff (!i_rst_n)
		$rose(o_mul_done)
			|-> $past(i_ce && i_mul_en);
	endproperty
	a_done_only_mul: assert property (p_done_only_mul)
		else $error("done rose without an accepted multiply");

	property p_mul_wins;
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && i_mul_en && (i_prod_wr.wr_high || i_prod_wr.wr_low))
			|=> {o_product_high_byte, o_product_low_byte}
			== $past(i_working_register) * $past(i_operand);
	endproperty
	a_mul_wins: assert property (p_mul_wins)
		else $error("byte write overrode a multiply");

	property p_wr_high;
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && !i_mul_en && i_prod_wr.wr_high)
			|=> o_product_high_byte == $past(i_prod_wr.data);
	endproperty
	a_wr_high: assert property (p_wr_high)
		else $error("high byte write lost");

	property p_wr_low;
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && !i_mul_en && i_prod_wr.wr_low)
			|=> o_product_low_byte == $past(i_prod_wr.data);
	endproperty
	a_wr_low: assert property (p_wr_low)
		else $error("low byte write lost");

	property p_keep_high;
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && !i_mul_en && !i_prod_wr.wr_high)
			|=> $stable(o_product_high_byte);
	endproperty
	a_keep_high: assert property (p_keep_high)
		else $error("high byte moved without a cause");

	property p_keep_low;
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && !i_mul_en && !i_prod_wr.wr_low)
			|=> $stable(o_product_low_byte);
	endproperty
	a_keep_low: assert property (p_keep_low)
		else $error("low byte moved without a cause");

	property p_hold_high;
		@(posedge i_clk) disable iff (!i_rst_n)
		(!i_ce)
			|=> $stable(o_product_high_byte) && $stable(o_alu_status_register);
	endproperty
	a_hold_high: assert property (p_hold_high)
		else $error("high byte or status moved with enable low");

	property p_stat_copy;
		@(posedge i_clk) disable iff (!i_rst_n)
		i_ce
			|=> o_alu_status_register == $past(i_alu_status_register);
	endproperty
	a_stat_copy: assert property (p_stat_copy)
		else $error("status copy altered");

	property p_next_visible;
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && i_mul_en) ##1 (i_ce && !i_mul_en
			&& !i_prod_wr.wr_high && !i_prod_wr.wr_low)
			|=> {o_product_high_byte, o_product_low_byte}
			== $past(i_working_register, 2) * $past(i_operand, 2);
	endproperty
	a_next_visible: assert property (p_next_visible)
		else $error("product not held for the next instruction");

	// No disable here: the reset is asynchronous and must clear at once
	property p_reset_zero;
		@(posedge i_clk)
		!i_rst_n
			|-> {o_product_high_byte, o_product_low_byte} == `HWM_PROD_RESET
			&& o_mul_done == `HWM_DONE_RESET;
	endproperty
	a_reset_zero: assert property (p_reset_zero)
		else $error("outputs not cleared in reset");
endmodule // hwm_multiplier

// >>> design/hwm_pkg.sv
package hwm_pkg;
	typedef struct packed {
		logic [7:0] high_byte;
		logic [7:0] low_byte;
	} hwm_prod_type;
	typedef struct packed {
		logic       wr_high;
		logic       wr_low;
		logic [7:0] data;
	} hwm_prodwr_type;
endpackage

// >>> verification/hwm_core_model.sv
`timescale 1ns/10ps
module hwm_core_model (
	// Issue side
	input  wire logic       i_clk,
	input  wire logic       i_go,
	input  wire logic [7:0] i_a,
	input  wire logic [7:0] i_b,
	// Toward the multiplier
	output logic            o_mul_en,
	output logic [7:0]      o_w,
	output logic [7:0]      o_b
);
	// Operand A always travels in the working register
	always_ff @(posedge i_clk) begin
		o_mul_en <= i_go;
		o_w      <= i_a;
		o_b      <= i_b;
	end
endmodule // hwm_core_model

// >>> verification/tb_top.sv
`timescale 1ns/10ps
module tb_top;
	logic                   i_clk = 1'b0;
	logic                   i_rst_n = 1'b0;
	logic                   go = 1'b0;
	logic [7:0]             a = 8'h00, b = 8'h00, st = 8'h00;
	logic [7:0]             w, opb, ph, pl, so;
	logic                   en, done;
	hwm_pkg::hwm_prodwr_type pw = '0;
	int                     err_count = 0, compares = 0, k;
	logic                   ce = 1'b1;
	logic [15:0]            pp;
	logic [31:0]            wide_result_bytes;
	logic [7:0] va [5] = '{8'h00, 8'hFF, 8'hFF, 8'h80, 8'h0D};
	logic [7:0] vb [5] = '{8'h37, 8'hFF, 8'h01, 8'h80, 8'hB2};
	hwm_core_model i_hwm_core_model (.i_clk(i_clk), .i_go(go), .i_a(a),
		.i_b(b), .o_mul_en(en), .o_w(w), .o_b(opb));
	hwm_multiplier i_hwm_multiplier (.i_clk(i_clk), .i_rst_n(i_rst_n),
		.i_ce(ce), .i_mul_en(en), .i_working_register(w),
		.i_operand(opb), .i_prod_wr(pw), .i_alu_status_register(st),
		.o_product_high_byte(ph), .o_product_low_byte(pl),
		.o_alu_status_register(so), .o_mul_done(done));
	initial forever #2 i_clk = ~i_clk;
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %0t got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic summarize;
		if (err_count == 0 && compares > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// Multiplies on five cycles in a row, then idles three; unsigned extremes expose truncation
	task automatic t_back_to_back;
		for (int i = 0; i < 8; i++) begin
			@(posedge i_clk);
			go <= (i < 5);
			a  <= va[i % 5];
			b  <= vb[i % 5];
			st <= 8'h11 * i;
			#1;
			k = (i < 2) ? 0 : ((i > 6) ? 4 : i - 2);
			if (i >= 2) check({ph, pl}, 16'(va[k]) * 16'(vb[k]));
			check(16'(done), 16'(i >= 2 && i < 7));
			if (i >= 1) check(16'(so), 16'(8'h11 * (i - 1)));
		end
	endtask
	// A byte write lands only in the addressed half
	task automatic t_byte_write;
		@(posedge i_clk);
		pw <= '{1'b1, 1'b0, 8'h5A};
		@(posedge i_clk);
		pw <= '0;
		#1;
		check({ph, pl}, {8'h5A, 8'h0D * 8'hB2});
	endtask
	// Enable low freezes everything, even a pending multiply
	task automatic t_ce_hold;
		@(posedge i_clk);
		ce <= 1'b0;
		go <= 1'b1;
		a  <= 8'h03;
		b  <= 8'h05;
		st <= 8'hA5;
		repeat (3) @(posedge i_clk);
		#1;
		check({ph, pl}, 16'h5A0A);
		check(16'(done), 16'h0000);
		check(16'(so), 16'h0077);
		@(posedge i_clk);
		ce <= 1'b1;
		go <= 1'b0;
		@(posedge i_clk);
		#1;
		check({ph, pl}, 16'h000F);
		check(16'(done), 16'h0001);
		check(16'(so), 16'h00A5);
	endtask
	task automatic t_low_write;
		@(posedge i_clk);
		pw <= '{1'b0, 1'b1, 8'hC3};
		@(posedge i_clk);
		pw <= '0;
		#1;
		check({ph, pl}, 16'h00C3);
	endtask
	// Multiply and byte write together; then a software signed fix-up
	task automatic t_mul_wins;
		@(posedge i_clk);
		go <= 1'b1;
		a  <= 8'h01;
		b  <= 8'h9C;
		@(posedge i_clk);
		go <= 1'b0;
		pw <= '{1'b1, 1'b1, 8'h66};
		@(posedge i_clk);
		pw <= '0;
		#1;
		check({ph, pl}, 16'h009C);
		check(16'(done), 16'h0001);
		check({8'(ph - (b[7] ? a : 8'h00) - (a[7] ? b : 8'h00)), pl},
			16'hFF9C);
	endtask
	// Reset in mid-run, then a request right at release
	task automatic t_reset_mid;
		@(posedge i_clk);
		i_rst_n <= 1'b0;
		@(posedge i_clk);
		#1;
		check({ph, pl}, 16'h0000);
		check(16'(so), 16'h0000);
		check(16'(done), 16'h0000);
		@(posedge i_clk);
		i_rst_n <= 1'b1;
		go <= 1'b1;
		a  <= 8'h10;
		b  <= 8'h10;
		@(posedge i_clk);
		go <= 1'b0;
		@(posedge i_clk);
		#1;
		check({ph, pl}, 16'h0100);
		check(16'(done), 16'h0001);
	endtask
	task automatic t_mul(input logic [7:0] x, input logic [7:0] y);
		@(posedge i_clk);
		go <= 1'b1;
		a  <= x;
		b  <= y;
		@(posedge i_clk);
		go <= 1'b0;
		@(posedge i_clk);
		#1;
		pp = {ph, pl};
	endtask
	// Software 16x16 product from four partial products
	task automatic t_wide;
		t_mul(8'hCD, 8'h34);
		wide_result_bytes = 32'(pp);
		t_mul(8'hAB, 8'h12);
		wide_result_bytes += {pp, 16'h0000};
		t_mul(8'hCD, 8'h12);
		wide_result_bytes += {8'h00, pp, 8'h00};
		t_mul(8'hAB, 8'h34);
		wide_result_bytes += {8'h00, pp, 8'h00};
		check(wide_result_bytes[31:16], 16'h0C37);
		check(wide_result_bytes[15:0], 16'h4FA4);
	endtask
	initial begin
		repeat (16) @(posedge i_clk);
		check({ph, pl}, 16'h0000);
		i_rst_n <= 1'b1;
		t_back_to_back();
		t_byte_write();
		t_ce_hold();
		t_low_write();
		t_mul_wins();
		t_reset_mid();
		t_wide();
		summarize();
	end
	// Watchdog against a stuck run
	initial begin
		#100000;
		err_count++;
		summarize();
	end
endmodule // tb_top
